// ==== rtl/scs_sequencer.sv ====
// Conversion sequencer of a 16-bit successive-approximation converter
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_sequencer #(
	parameter int RES_BITS = `SCS_RES_BITS,
	parameter bit FAST_VARIANT = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic convert_trigger,
	input wire logic comparator_out,
	input wire logic early_stop_n,
	input wire logic conv_clk,
	output scs_pkg::scs_out_t pins,
	output logic [15:0] dac_bits,
	output logic conv_clk_out
);
	import scs_pkg::*;

	// ----------------------------------------------------------------
	// Local constants
	// ----------------------------------------------------------------
	// Half period of the internal clock for the selected variant
	localparam logic [`SCS_DIV_W-1:0] HALF_DIV = FAST_VARIANT ?
		`SCS_DIV_W'(`SCS_HALF_FAST) : `SCS_DIV_W'(`SCS_HALF_SLOW);

	// Divider count at which the gated clock toggles
	localparam logic [`SCS_DIV_W-1:0] DIV_TOP = HALF_DIV - `SCS_DIV_W'(1);

	// Divider count, late in the low phase, at which decision inputs are held
	localparam logic [`SCS_DIV_W-1:0] DIV_SAMPLE = HALF_DIV - `SCS_DIV_W'(`SCS_COMP_LEAD);

	// Number of clock rises in a full conversion
	localparam logic [`SCS_STEP_W-1:0] RISE_LAST = `SCS_STEP_W'(`SCS_CLK_CYCLES);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The bit pointer and the pin map are written for sixteen bits only
	if (RES_BITS != `SCS_RES_BITS) begin : g_bad_res
		$error("scs_sequencer serves only a 16-bit register");
	end

	// The hold point must sit inside the low half period, clear of both edges
	if (HALF_DIV <= `SCS_DIV_W'(`SCS_COMP_LEAD + 1)) begin : g_bad_div
		$error("scs_sequencer half period too short for the decision hold point");
	end

	// ----------------------------------------------------------------
	// Decision arithmetic
	// ----------------------------------------------------------------
	// Next register value at a decision: keep or drop the bit under test,
	// then raise the next lower bit as the new trial
	function automatic logic [15:0] decide_bit(
		input logic [15:0] cur,
		input logic [15:0] hot,
		input logic keep
	);
		logic [15:0] kept;
		kept = keep ? hot : 16'h0000;
		decide_bit = (cur & ~hot) | kept | (hot >> 1);
	endfunction : decide_bit

	// ----------------------------------------------------------------
	// Conversion clock generation (mclk domain)
	// ----------------------------------------------------------------
	logic trig_s1;
	logic trig_s2;
	logic trig_s3;
	logic trig_fall;
	logic conv_init;
	logic [`SCS_DIV_W-1:0] div_cnt;
	logic gate_clk;
	logic [`SCS_STEP_W-1:0] rise_cnt;
	logic run_m;
	logic last_fall;
	logic sample_now;
	logic status_q;
	logic comp_m1;
	logic comp_m2;
	logic comp_hold;
	logic stop_m1;
	logic stop_m2;
	logic stop_hold;
	logic done_s1;
	logic done_s2;
	scs_state_t state;

	// Trigger pin synchroniser; only the second stage feeds logic,
	// the third stage is just the delayed copy for edge detection
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end else begin
			trig_s1 <= convert_trigger;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end

	// Trailing edge of the trigger pulse starts the conversion
	assign trig_fall = trig_s3 & ~trig_s2;

	// One-cycle initialise strobe from a flop, so the reset it makes is clean
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_init <= 1'b0;
		end else begin
			conv_init <= trig_fall;
		end
	end

	// Sequencer: the trailing edge restarts even a running conversion
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SCS_IDLE;
		end else if (trig_fall) begin
			state <= SCS_ARM;
		end else begin
			case (state)
				SCS_IDLE: state <= SCS_IDLE;
				SCS_ARM: state <= SCS_RUN;
				SCS_RUN: begin
					if (last_fall) begin
						state <= SCS_IDLE;
					end
				end
				default: state <= SCS_IDLE;
			endcase
		end
	end

	assign run_m = (state == SCS_RUN);

	// Unless a trigger restarts it, the run ends on a natural falling edge, so the last high phase is not cut short;
	// the rise count is a backstop should the done report be lost
	assign last_fall = run_m && gate_clk && (div_cnt == DIV_TOP) &&
		(done_s2 || rise_cnt == RISE_LAST);

	// Decision inputs are captured just before each rise, at the end of the comparison period
	assign sample_now = run_m && !gate_clk && (div_cnt == DIV_SAMPLE);

	// Divider and gated clock; the clock stays low while inhibited
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			gate_clk <= 1'b0;
			rise_cnt <= '0;
		end else if (!run_m || trig_fall) begin
			div_cnt <= '0;
			gate_clk <= 1'b0;
			rise_cnt <= '0;
		end else if (div_cnt == DIV_TOP) begin
			div_cnt <= '0;
			gate_clk <= ~gate_clk;
			if (!gate_clk) begin
				rise_cnt <= rise_cnt + `SCS_STEP_W'(1);
			end
		end else begin
			div_cnt <= div_cnt + `SCS_DIV_W'(1);
		end
	end

	assign conv_clk_out = gate_clk;

	// Status flag: set by the trigger, dropped at the last falling clock edge.
	// A trigger in the same cycle as the end wins, so a restart is never lost.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= 1'b0;
		end else if (trig_fall) begin
			status_q <= 1'b1;
		end else if (last_fall) begin
			status_q <= 1'b0;
		end
	end

	// Comparator and early-stop pins pass two flops before anything reads them
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comp_m1 <= 1'b0;
			comp_m2 <= 1'b0;
			stop_m1 <= 1'b1;
			stop_m2 <= 1'b1;
		end else begin
			comp_m1 <= comparator_out;
			comp_m2 <= comp_m1;
			stop_m1 <= early_stop_n;
			stop_m2 <= stop_m1;
		end
	end

	// Held copies stay still across the rise that uses them, which is what makes
	// the hand-over into the conversion clock domain safe without a third flop
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comp_hold <= 1'b0;
			stop_hold <= 1'b1;
		end else if (sample_now) begin
			comp_hold <= comp_m2;
			stop_hold <= stop_m2;
		end
	end

	// Done level from the conversion clock domain; only the second flop is read
	logic conv_done;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
		end else begin
			done_s1 <= conv_done;
			done_s2 <= done_s1;
		end
	end

	// ----------------------------------------------------------------
	// Successive approximation (conversion clock domain)
	// ----------------------------------------------------------------
	logic conv_rst_n;
	logic armed;
	logic active;
	logic [15:0] step_hot;
	logic [15:0] sar;
	logic serial_bit;
	logic [15:0] next_sar;

	// Sequence flags restart on the trigger's trailing edge. The clock is parked
	// low while this reset stands, so its release never meets a clock edge.
	assign conv_rst_n = rst_n & ~conv_init;

	// Decision for the bit under test from the held comparator
	assign next_sar = decide_bit(sar, step_hot, comp_hold);

	// Step control: first rise is the set-up step, then one decision per rise
	always_ff @(posedge conv_clk or negedge conv_rst_n) begin
		if (!conv_rst_n) begin
			armed <= 1'b1;
			active <= 1'b0;
			conv_done <= 1'b0;
			step_hot <= '0;
		end else if (armed) begin
			armed <= 1'b0;
			active <= 1'b1;
			step_hot <= `SCS_ONE_HOT_TOP;
		end else if (active) begin
			if (!stop_hold) begin
				// Strap shows the bit n+1 trial, so bit n was the last one wanted
				active <= 1'b0;
				conv_done <= 1'b1;
			end else begin
				step_hot <= step_hot >> 1;
				if (step_hot[0]) begin
					active <= 1'b0;
					conv_done <= 1'b1;
				end
			end
		end
	end

	// Result register; it only moves on rising clock edges, never on the restart
	always_ff @(posedge conv_clk or negedge rst_n) begin
		if (!rst_n) begin
			sar <= `SCS_SAR_RESET;
		end else if (armed) begin
			sar <= `SCS_SAR_TRIAL;
		end else if (active && stop_hold) begin
			sar <= next_sar;
		end
	end

	// Serial bit is the decision made at this edge; the set-up step sends a
	// filler bit that the receiver's seventeenth shift discards
	always_ff @(posedge conv_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_bit <= 1'b0;
		end else if (armed) begin
			serial_bit <= 1'b0;
		end else if (active && stop_hold) begin
			serial_bit <= comp_hold;
		end
	end

	// Feedback converter sees the true register bits directly
	assign dac_bits = sar;

	// ----------------------------------------------------------------
	// Pins, result negative true, status and clock true high
	// ----------------------------------------------------------------
	// Inverted code gives complementary straight or offset binary by range
	assign pins.parallel_n = ~sar;
	assign pins.serial_n = ~serial_bit;
	assign pins.status = status_q;
	assign pins.conv_clk = gate_clk;

endmodule : scs_sequencer

// ==== rtl/scs_consts.svh ====
// Constant definitions for the successive-approximation conversion sequencer
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_RES_BITS 16
`define SCS_STEP_W 5
`define SCS_STEP_FIRST 5'h0000
`define SCS_STEP_LAST 5'h0010
`define SCS_CLK_CYCLES 17
`define SCS_MCLK_HZ 200000000
`define SCS_FAST_CLK_HZ 1600000
`define SCS_SLOW_CLK_HZ 933000
`define SCS_DIV_W 12
`define SCS_HALF_FAST ((`SCS_MCLK_HZ / `SCS_FAST_CLK_HZ) / 2)
`define SCS_HALF_SLOW ((`SCS_MCLK_HZ / `SCS_SLOW_CLK_HZ) / 2)
`define SCS_SAR_RESET 16'h0000
`define SCS_ONE_HOT_TOP 16'h8000
`define SCS_SAR_TRIAL 16'h8000
`define SCS_COMP_LEAD 4

`endif

// ==== rtl/scs_pkg.sv ====
// Types shared by the conversion sequencer
package scs_pkg;

	typedef enum logic [1:0] {
		SCS_IDLE = 2'b00,
		SCS_ARM = 2'b01,
		SCS_RUN = 2'b10
	} scs_state_t;

	// Result as presented on the pins, negative true
	typedef struct packed {
		logic [15:0] parallel_n;
		logic serial_n;
		logic status;
		logic conv_clk;
	} scs_out_t;

endpackage : scs_pkg

// ==== verif/scs_checker_assertions.sv ====
// Concurrent checks on the conversion sequencer pins
`timescale 1ns/1ps
module scs_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic convert_trigger,
	input wire scs_pkg::scs_out_t pins,
	input wire logic [15:0] dac_bits,
	input wire logic conv_clk_out
);
	import scs_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [4:0] rises;
	// Clock rises since the last trigger; saturates so a runaway clock cannot wrap back to legal
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rises <= 5'h0;
		else if ($fell(convert_trigger))
			rises <= 5'h0;
		else if ($rose(conv_clk_out) && rises != 5'h1f)
			rises <= rises + 5'h1;
	end
	// Clock parked low for a while once status drops
	sequence clk_parked;
		!conv_clk_out [*8];
	endsequence
	chk_trig_starts: assert property ($fell(convert_trigger) |-> ##[1:700] pins.status)
		else $error("status did not rise after trigger");
	chk_clk_runs: assert property (pins.status && !conv_clk_out |-> ##[1:150] conv_clk_out)
		else $error("clock stalled during conversion");
	chk_rise_limit: assert property (rises <= 5'd17)
		else $error("more than 17 clock cycles");
	chk_clk_parks: assert property ($fell(pins.status) |-> ##[1:200] clk_parked)
		else $error("clock not parked after status fell");
	chk_par_edge: assert property (!$stable(pins.parallel_n) |-> $rose(conv_clk_out))
		else $error("parallel changed off a rising clock");
	chk_ser_edge: assert property (!$stable(pins.serial_n) |-> $rose(conv_clk_out))
		else $error("serial changed off a rising clock");
	chk_dac_inverse: assert property (pins.parallel_n == ~dac_bits)
		else $error("parallel pins not inverse of feedback bits");
	chk_lead_time: assert property ($fell(pins.status) |-> $past(pins.parallel_n, 4) == pins.parallel_n)
		else $error("parallel not settled before status fell");
endmodule : scs_checker

// ==== verif/scs_host_model.sv ====
// Host model capturing serial and parallel results
`timescale 1ns/1ps
module scs_host_model (
	input wire logic conv_clk_out,
	input wire scs_pkg::scs_out_t pins,
	output logic [15:0] ser_word,
	output logic [15:0] par_word
);
	import scs_pkg::*;
	// Shift on the falling clock; the invalid first bit falls off the top by the 17th edge
	always_ff @(negedge conv_clk_out) begin
		ser_word <= {ser_word[14:0], pins.serial_n};
	end
	// Latch the word on the falling status edge
	always_ff @(negedge pins.status) begin
		par_word <= pins.parallel_n;
	end
endmodule : scs_host_model

// ==== verif/sar_conversion_sequencer_test.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module sar_conversion_sequencer_test;
	import scs_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic convert_trigger = 1'b0;
	logic stop_mode = 1'b0;
	logic [15:0] target = 16'h0000;
	logic comparator_out;
	logic early_stop_n;
	logic conv_clk_out;
	logic [15:0] dac_bits, ser_word, par_word;
	logic [15:0] vals [5] = '{16'h0000, 16'hffff, 16'h677a, 16'h8000, 16'h0001};
	scs_out_t pins;
	int fail_count = 0;
	int num_checks = 0;
	int rises = 0;
	always #2.5 mclk = ~mclk;
	// Comparator keeps a trial bit while the feedback code does not exceed the input
	assign comparator_out = (dac_bits <= target);
	// Short-cycle runs strap early stop to the bit 11 pin
	assign early_stop_n = stop_mode ? pins.parallel_n[5] : 1'b1;
	always @(posedge conv_clk_out) rises = rises + 1;
	scs_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .convert_trigger(convert_trigger),
		.comparator_out(comparator_out), .early_stop_n(early_stop_n), .conv_clk(conv_clk_out),
		.pins(pins), .dac_bits(dac_bits), .conv_clk_out(conv_clk_out));
	scs_host_model u_host (.conv_clk_out(conv_clk_out), .pins(pins), .ser_word(ser_word), .par_word(par_word));
	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check16
	// Positive trigger pulse of 50 ns; the conversion starts on its trailing edge
	task automatic pulse(input logic [15:0] val);
		@(posedge mclk);
		#1 target = val;
		convert_trigger = 1'b1;
		repeat (10) @(posedge mclk);
		#1 convert_trigger = 1'b0;
		rises = 0;
	endtask : pulse
	// Bounded wait for status to rise and fall, then let the last falling clock land
	task automatic await_done();
		logic seen;
		seen = 1'b0;
		repeat (6000) begin
			@(posedge mclk);
			if (pins.status === 1'b1)
				seen = 1'b1;
			if (seen && pins.status === 1'b0)
				break;
		end
		repeat (200) @(posedge mclk);
		check16("status pulse", 16'h0001, {15'h0, seen});
		check16("status ended", 16'h0000, {15'h0, pins.status});
	endtask : await_done
	task automatic t_reset();
		check16("reset parallel", 16'hffff, pins.parallel_n);
		check16("reset status clk", 16'h0000, {14'h0, pins.status, conv_clk_out});
	endtask : t_reset
	task automatic t_full(input logic [15:0] val);
		pulse(val);
		await_done();
		check16("parallel latch", ~val, par_word);
		check16("serial word", ~val, ser_word);
		check16("dac bits", val, dac_bits);
		check16("clock rises", 16'd17, 16'(rises));
	endtask : t_full
	// Short cycle at 10 bits: bit 11 pin left low as a trial, lower pins high
	task automatic t_short();
		stop_mode = 1'b1;
		pulse(16'hb3c9);
		await_done();
		check16("short top bits", {~target[15:6], 6'h1f}, par_word);
		check16("short rises", 16'd12, 16'(rises));
		stop_mode = 1'b0;
	endtask : t_short
	// Trigger in mid-conversion restarts from the first step
	task automatic t_restart();
		pulse(16'h1234);
		repeat (800) @(posedge mclk);
		pulse(16'hc0de);
		await_done();
		check16("restart parallel", 16'h3f21, par_word);
		check16("restart serial", 16'h3f21, ser_word);
		check16("restart rises", 16'd17, 16'(rises));
	endtask : t_restart
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (6) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_reset();
		foreach (vals[i])
			t_full(vals[i]);
		t_short();
		t_restart();
		report_and_stop();
	end
	// Watchdog well beyond eight conversions at the fast clock
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
endmodule : sar_conversion_sequencer_test
bind scs_sequencer scs_checker u_chk (.mclk(mclk), .rst_n(rst_n), .convert_trigger(convert_trigger),
	.pins(pins), .dac_bits(dac_bits), .conv_clk_out(conv_clk_out));
